/* File: core/rsl_pkg.sv */
/*
 Package for the reset source logic: timing counts, cause flag layout,
 sequencer states and the packed carriers used by rsl_reset_source.
 Assumes a single 100 MHz system clock.
*/
package rsl_pkg;
    // Pin low-time accepted as a reset request, in clock cycles
    localparam int unsigned PIN_ACCEPT_CYCLES = 3;
    // Pin low-time the outside party must provide
    localparam int unsigned PIN_REQUIRED_CYCLES = 4;
    // Length of the system reset pulse issued to the core
    localparam int unsigned SYS_RESET_CYCLES = 16;
    localparam int unsigned CNT_W = 5;
    // Cause register layout
    localparam int unsigned CAUSE_W = 3;
    localparam int unsigned CAUSE_WDOG_BIT = 0;
    localparam int unsigned CAUSE_PIN_BIT = 1;
    localparam int unsigned CAUSE_POR_BIT = 2;
    localparam logic [2:0] CAUSE_RESET_VAL = 3'h4;
    // Watchdog reset select option unprogrammed state
    localparam logic WDOG_SEL_RESET = 1'h1;

    typedef enum logic [2:0] {
        RSL_RUN = 3'h1,
        RSL_SYS_RESET = 3'h2,
        RSL_POR_HOLD = 3'h4
    } rsl_state_t;

    // Event inputs to the sequencer
    typedef struct packed {
        logic wdog_expire;
        logic core_active;
        logic brownout;
    } rsl_events_t;

    // Outputs toward the core
    typedef struct packed {
        logic sys_reset;
        logic por_reset;
        logic wdog_irq;
    } rsl_ctrl_t;
endpackage : rsl_pkg

/* File: core/rsl_pin_filter.sv */
/*
 Reset pin filter: two-stage synchroniser and low-time counter.
 Assumes reset_pin_n is asynchronous to clk and active low.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_pin_filter #(
    parameter int unsigned ACCEPT = rsl_pkg::PIN_ACCEPT_CYCLES
) (
    input wire logic clk,          // System clock
    input wire logic reset_n,      // Synchronous reset, active low
    input wire logic reset_pin_n,  // Raw reset pin
    output logic request           // One-cycle pulse, pin low long enough
);
    logic sync_a;
    logic sync_b;
    logic [rsl_pkg::CNT_W-1:0] low_cnt;
    logic [rsl_pkg::CNT_W-1:0] next_low_cnt;
    logic next_request;

    // Count only after the second flop; first flop feeds nothing else
    always_comb begin
        next_low_cnt = low_cnt;
        next_request = 1'h0;
        if (sync_b) begin
            next_low_cnt = '0;
        end else if (low_cnt < rsl_pkg::CNT_W'(ACCEPT)) begin
            next_low_cnt = low_cnt + 1'h1;
            // Three accepted since a four-cycle pulse may be caught short
            next_request = (low_cnt == rsl_pkg::CNT_W'(ACCEPT - 1));
        end
    end

    // Pin synchroniser and counter registers; pin idles high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync_a <= 1'h1;
            sync_b <= 1'h1;
            low_cnt <= '0;
            request <= 1'h0;
        end else begin
            sync_a <= reset_pin_n;
            sync_b <= sync_a;
            low_cnt <= next_low_cnt;
            request <= next_request;
        end
    end

    a_pin_accept: assert property (@(posedge clk) disable iff (!reset_n)
        (!sync_b [*3]) ##0 $past(sync_b, 3) |=> request)
        else $error("pin low three cycles not accepted");
    a_pin_single: assert property (@(posedge clk) disable iff (!reset_n)
        request |=> !request)
        else $error("pin request longer than one cycle");
endmodule : rsl_pin_filter
`default_nettype wire

/* File: core/rsl_reset_source.sv */
/*
 Reset source logic: merges reset pin, watchdog expiry and brown-out into
 a system reset, a power-on reset or a watchdog interrupt, and keeps the
 reset cause flags. Assumes the watchdog and brown-out inputs are on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_reset_source #(
    parameter int unsigned SYS_CYCLES = rsl_pkg::SYS_RESET_CYCLES
) (
    input wire logic clk,                  // System clock, 100 MHz
    input wire logic reset_n,              // Synchronous reset, active low
    input wire logic reset_pin_n,          // Board reset pin, asynchronous
    input wire logic wdog_expire,          // Watchdog time-out pulse
    input wire logic core_active,          // Core in normal or halt mode
    input wire logic brownout,             // Supply below brown-out threshold
    input wire logic watchdog_reset_select_option, // 1 reset, 0 interrupt
    input wire logic cause_clear,          // Software clears cause register
    output logic sys_reset,                // System reset to the core
    output logic por_reset,                // Full power-on reset to the core
    output logic wdog_irq,                 // Watchdog interrupt pulse
    output logic [2:0] reset_cause_register // Cause flags
);
    logic pin_request;
    rsl_pkg::rsl_state_t state;
    rsl_pkg::rsl_state_t next_state;
    logic [rsl_pkg::CNT_W-1:0] cnt;
    logic [rsl_pkg::CNT_W-1:0] next_cnt;
    logic [2:0] next_cause;
    rsl_pkg::rsl_events_t ev;
    rsl_pkg::rsl_ctrl_t ctrl;
    rsl_pkg::rsl_ctrl_t next_ctrl;

    rsl_pin_filter #(
        .ACCEPT(rsl_pkg::PIN_ACCEPT_CYCLES)
    ) u_pin (
        .clk(clk),
        .reset_n(reset_n),
        .reset_pin_n(reset_pin_n),
        .request(pin_request)
    );

    assign ev = '{wdog_expire: wdog_expire, core_active: core_active,
                  brownout: brownout};

    // Watchdog reset only counts while the core runs or halts
    function automatic logic wdog_resets(input rsl_pkg::rsl_events_t e, input logic sel);
        wdog_resets = e.wdog_expire && e.core_active && (sel == rsl_pkg::WDOG_SEL_RESET);
    endfunction : wdog_resets

    // Sequencer next state; brown-out outranks everything
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cause = reset_cause_register;
        next_ctrl = '0;
        if (cause_clear) begin
            next_cause = '0;
        end
        unique case (state)
            rsl_pkg::RSL_RUN: begin
                if (ev.brownout) begin
                    next_state = rsl_pkg::RSL_POR_HOLD;
                    next_cause = 3'h0;
                    next_cause[rsl_pkg::CAUSE_POR_BIT] = 1'h1;
                end else if (wdog_resets(ev, watchdog_reset_select_option)) begin
                    next_state = rsl_pkg::RSL_SYS_RESET;
                    next_cnt = '0;
                    next_cause[rsl_pkg::CAUSE_WDOG_BIT] = 1'h1;
                end else if (pin_request) begin
                    next_state = rsl_pkg::RSL_SYS_RESET;
                    next_cnt = '0;
                    next_cause[rsl_pkg::CAUSE_PIN_BIT] = 1'h1;
                end else if (ev.wdog_expire && ev.core_active) begin
                    next_ctrl.wdog_irq = 1'h1;
                end
            end
            rsl_pkg::RSL_SYS_RESET: begin
                if (ev.brownout) begin
                    next_state = rsl_pkg::RSL_POR_HOLD;
                    next_cause[rsl_pkg::CAUSE_POR_BIT] = 1'h1;
                end else if (cnt == rsl_pkg::CNT_W'(SYS_CYCLES - 1)) begin
                    next_state = rsl_pkg::RSL_RUN;
                end else begin
                    next_cnt = cnt + 1'h1;
                end
            end
            rsl_pkg::RSL_POR_HOLD: begin
                // Stay in power-on reset until supply back, then full sequence
                if (!ev.brownout) begin
                    next_state = rsl_pkg::RSL_SYS_RESET;
                    next_cnt = '0;
                end
            end
        endcase
        next_ctrl.sys_reset = (next_state != rsl_pkg::RSL_RUN);
        next_ctrl.por_reset = (next_state == rsl_pkg::RSL_POR_HOLD);
    end

    // Sequencer and output registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= rsl_pkg::RSL_POR_HOLD;
            cnt <= '0;
            reset_cause_register <= rsl_pkg::CAUSE_RESET_VAL;
            // Core held in power-on reset, no interrupt, until release
            ctrl <= '{sys_reset: 1'h1,
                      por_reset: 1'h1,
                      wdog_irq: 1'h0};
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            reset_cause_register <= next_cause;
            ctrl <= next_ctrl;
        end
    end

    assign sys_reset = ctrl.sys_reset;
    assign por_reset = ctrl.por_reset;
    assign wdog_irq = ctrl.wdog_irq;

    a_wdog_reset: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && !brownout && wdog_expire && core_active
         && watchdog_reset_select_option) |=> sys_reset && !wdog_irq)
        else $error("watchdog expiry did not reset");
    a_wdog_irq: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && !brownout && wdog_expire && core_active
         && !watchdog_reset_select_option && !pin_request) |=> wdog_irq && !sys_reset)
        else $error("watchdog interrupt mode misbehaved");
    a_wdog_cause: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && !brownout && wdog_expire && core_active
         && watchdog_reset_select_option) |=> reset_cause_register[rsl_pkg::CAUSE_WDOG_BIT])
        else $error("watchdog cause flag not set");
    a_pin_reset: assert property (@(posedge clk) disable iff (!reset_n)
        (pin_request && state == rsl_pkg::RSL_RUN) |=> sys_reset [*8])
        else $error("pin request did not hold system reset");
    a_por_recover: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && brownout) |=> por_reset ##0 sys_reset)
        else $error("brown-out did not give power-on reset");
    a_pin_chain: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && !brownout && !wdog_expire && $fell(reset_pin_n))
        |-> ##[1:8] (pin_request || reset_pin_n))
        else $error("pin request not raised after sync");
    a_seq_len: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(sys_reset) |-> $past(state) == rsl_pkg::RSL_SYS_RESET)
        else $error("system reset ended outside sequence");
    a_por_exit: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(por_reset) |-> sys_reset)
        else $error("power-on reset released without system reset");

    // Interrupt mode hazards: a stuck pulse would flood the core, and an
    // interrupt must never come with a reset, or the handler would be lost
    a_irq_single: assert property (@(posedge clk) disable iff (!reset_n)
        wdog_irq |=> !wdog_irq)
        else $error("watchdog interrupt longer than one cycle");
    a_irq_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
        wdog_irq |-> !sys_reset)
        else $error("watchdog interrupt during system reset");
    a_irq_source: assert property (@(posedge clk) disable iff (!reset_n)
        wdog_irq |-> $past(wdog_expire) && $past(core_active))
        else $error("watchdog interrupt without an expiry");

    // Expiry while the core sleeps is ignored in both option settings
    a_sleep_ignore: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && !brownout && wdog_expire && !core_active
         && !pin_request) |=> !sys_reset && !wdog_irq)
        else $error("expiry acted on while core asleep");

    // Clearing the cause flags with no new event empties the register
    a_cause_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (cause_clear && state == rsl_pkg::RSL_RUN && !brownout && !wdog_expire
         && !pin_request) |=> reset_cause_register == '0)
        else $error("cause register not cleared");

    // A clear in the same cycle as a watchdog reset must not hide the cause
    a_cause_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
        (cause_clear && state == rsl_pkg::RSL_RUN && !brownout
         && wdog_resets(ev, watchdog_reset_select_option))
        |=> reset_cause_register[rsl_pkg::CAUSE_WDOG_BIT])
        else $error("clear beat a watchdog cause");

    // Brown-out from run leaves only the power-on cause behind
    a_por_cause: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_RUN && brownout)
        |=> reset_cause_register == rsl_pkg::CAUSE_RESET_VAL)
        else $error("brown-out cause not recorded");

    // Power-on reset stands for as long as the supply is low
    a_por_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_POR_HOLD && brownout) |=> por_reset && sys_reset)
        else $error("power-on reset dropped while supply low");

    // Sequence counter stays inside the pulse length; a runaway would
    // leave the core in reset for good
    a_cnt_range: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rsl_pkg::RSL_SYS_RESET) |-> cnt < rsl_pkg::CNT_W'(SYS_CYCLES))
        else $error("sequence counter out of range");
    a_state_legal: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot(state))
        else $error("sequencer state not one-hot");

    c_wdog_reset: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_cause_register[rsl_pkg::CAUSE_WDOG_BIT]));
    c_wdog_irq: cover property (@(posedge clk) disable iff (!reset_n) wdog_irq);
    c_pin_reset: cover property (@(posedge clk) disable iff (!reset_n)
        pin_request ##1 sys_reset);
    c_brownout: cover property (@(posedge clk) disable iff (!reset_n) $fell(por_reset));
    c_seq_done: cover property (@(posedge clk) disable iff (!reset_n) $fell(sys_reset));
endmodule : rsl_reset_source
`default_nettype wire

/* File: tb/rsl_pin_source.sv */
/*
 Board reset source model: pulls the reset pin low for whole clock cycles.
 Assumes the pin has a pull-up, so it reads high whenever not pulled.
*/
`timescale 1ns/1ps
`default_nettype none
module rsl_pin_source (
    input wire logic clk,    // System clock
    output logic reset_pin_n // Board reset pin
);
    // Pull-up level while nobody drives the pin
    initial reset_pin_n = 1'h1;
    // Changes just after an edge so the low time is a whole cycle count
    task automatic hold_low(input int cycles);
        @(posedge clk);
        reset_pin_n <= 1'h0;
        repeat (cycles) @(posedge clk);
        reset_pin_n <= 1'h1;
    endtask : hold_low
endmodule : rsl_pin_source
`default_nettype wire

/* File: tb/test_reset_source_logic.sv */
/*
 Testbench for the reset source logic: watchdog, pin, brown-out, clear.
 Assumes a 100 MHz clock and the pin source model on the reset pin.
*/
`timescale 1ns/1ps
`default_nettype none
module test_reset_source_logic;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic reset_pin_n;
    logic wdog_expire = 1'h0;
    logic core_active = 1'h1;
    logic brownout = 1'h0;
    logic wdog_sel = 1'h1;
    logic cause_clear = 1'h0;
    logic sys_reset, por_reset, wdog_irq;
    logic [2:0] cause;
    int bad_count = 0;
    int compares = 0;
    // Clock, 10 ns period
    always #5 clk = ~clk;
    rsl_pin_source i_pin (.clk(clk), .reset_pin_n(reset_pin_n));
    rsl_reset_source #(.SYS_CYCLES(16)) i_dut (.clk(clk), .reset_n(reset_n),
        .reset_pin_n(reset_pin_n), .wdog_expire(wdog_expire), .core_active(core_active),
        .brownout(brownout), .watchdog_reset_select_option(wdog_sel),
        .cause_clear(cause_clear), .sys_reset(sys_reset), .por_reset(por_reset),
        .wdog_irq(wdog_irq), .reset_cause_register(cause));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // Sample 1 ns after the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Bounded wait for the system reset to end, counting its high cycles
    task automatic wait_run(output int len);
        len = 0;
        while (sys_reset !== 1'h0) begin
            len++;
            if (len > 60) begin
                bad_count++;
                summarize();
            end
            step(1);
        end
    endtask : wait_run
    // One-cycle expiry; option and core mode change with it
    task automatic pulse_wdog(input logic sel, input logic act);
        @(posedge clk);
        wdog_expire <= 1'h1;
        wdog_sel <= sel;
        core_active <= act;
        step(1);
        wdog_expire <= 1'h0;
    endtask : pulse_wdog
    task automatic clear_cause();
        @(posedge clk);
        cause_clear <= 1'h1;
        @(posedge clk);
        cause_clear <= 1'h0;
        step(1);
        check("cause cleared", 8'(cause), 8'h0);
    endtask : clear_cause
    // Main sequence: each block sets up one case and judges it
    initial begin
        int len;
        int n;
        step(5);
        check("reset outputs", {6'h0, sys_reset, por_reset}, 8'h3);
        check("reset cause", 8'(cause), 8'h4);
        @(posedge clk);
        reset_n <= 1'h1;
        step(2);
        check("por released", 8'(por_reset), 8'h0);
        wait_run(len);
        clear_cause();
        // Expiry with reset option: 16-cycle reset and watchdog flag
        pulse_wdog(1'h1, 1'h1);
        check("wdog reset", 8'(sys_reset), 8'h1);
        check("wdog cause", 8'(cause), 8'h1);
        wait_run(len);
        check("reset length", 8'(len), 8'h10);
        clear_cause();
        // Interrupt option: exactly one irq pulse, never a reset
        pulse_wdog(1'h0, 1'h1);
        n = 0;
        for (int i = 0; i < 4; i++) begin
            n += int'(wdog_irq === 1'h1);
            n += 8 * int'(sys_reset !== 1'h0);
            step(1);
        end
        check("irq only", 8'(n), 8'h1);
        // Core asleep: expiry must be ignored
        pulse_wdog(1'h1, 1'h0);
        step(2);
        check("asleep expiry", {5'h0, cause}, 8'h0);
        core_active <= 1'h1;
        // Two low cycles are refused, three are taken
        i_pin.hold_low(2);
        step(10);
        check("short pin", {4'h0, sys_reset, cause}, 8'h0);
        i_pin.hold_low(3);
        step(6);
        check("pin three", {4'h0, sys_reset, cause}, 8'h0a);
        wait_run(len);
        clear_cause();
        i_pin.hold_low(4);
        step(6);
        check("pin four", {4'h0, sys_reset, cause}, 8'h0a);
        wait_run(len);
        // Brown-out: full power-on reset until recovery, then system reset
        @(posedge clk);
        brownout <= 1'h1;
        step(2);
        check("brownout", {3'h0, sys_reset, por_reset, cause}, 8'h1c);
        step(4);
        brownout <= 1'h0;
        step(3);
        check("recovery", {6'h0, sys_reset, por_reset}, 8'h2);
        wait_run(len);
        summarize();
    end
endmodule : test_reset_source_logic
`default_nettype wire
